// ===== rtl/branch_unit_pkg.sv
package branch_unit_pkg;
  localparam int PC_W = 16;
  localparam int SR_W = 16;
  localparam int INSTR_W = 16;
  localparam int OFF_W = 10;
  localparam int OFF_LSB = 0;
  localparam int COND_LSB = 10;
  localparam int COND_W = 3;
  localparam logic [COND_W-1:0] COND_GE = 3'h5;
  localparam logic [COND_W-1:0] COND_LT = 3'h6;
  localparam int OFF_SHIFT = 1;
  localparam logic [PC_W-1:0] INSTR_BYTES = 16'h0002;
  localparam int RANGE_MIN_WORDS = -511;
  localparam int RANGE_MAX_WORDS = 512;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [SR_W-1:0] SR_RST = 16'h0000;
endpackage

// ===== rtl/branch_target_calc.sv
`timescale 1ns/1ps
module branch_target_calc #(
  parameter int PC_W = 16,
  parameter int OFF_W = 10,
  parameter int OFF_SHIFT = 1
) (
  // operands
  input wire logic [PC_W-1:0] i_pc,
  input wire logic [OFF_W-1:0] i_offset,
  // result
  output logic [PC_W-1:0] o_target
);
  logic [PC_W-1:0] sext_off;

  // widen first, then double, then add to the already advanced pc
  assign sext_off = {{(PC_W-OFF_W){i_offset[OFF_W-1]}}, i_offset};
  assign o_target = i_pc + (sext_off << OFF_SHIFT);

endmodule // branch_target_calc

// ===== rtl/signed_conditional_branch_unit.sv
// Behaviour
// - greater-or-equal branch jumps to the relative target when negative xor overflow is 0.
// - greater-or-equal branch falls through to the next instruction when negative xor overflow is 1.
// - less-than branch jumps to the relative target when negative xor overflow is 1.
// - less-than branch falls through to the next instruction when negative xor overflow is 0.
// - a taken branch adds twice the 10-bit signed offset from the low instruction bits to the pc.
// - both branches, taken or not, leave every status flag unchanged.
// - the reach is -511 to +512 words relative to the jump instruction itself.
`timescale 1ns/1ps
module signed_conditional_branch_unit (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // issued jump instruction
  input wire logic i_valid,
  input wire logic [branch_unit_pkg::INSTR_W-1:0] i_instr,
  input wire logic [branch_unit_pkg::PC_W-1:0] i_pc,
  // status register
  input wire logic [branch_unit_pkg::SR_W-1:0] i_sr,
  input wire logic i_flag_n,
  input wire logic i_flag_v,
  // resolution
  output logic o_done,
  output logic o_taken,
  output logic [branch_unit_pkg::PC_W-1:0] o_pc_next,
  // status write-back
  output logic o_sr_we,
  output logic [branch_unit_pkg::SR_W-1:0] o_sr
);
  import branch_unit_pkg::*;

  typedef struct packed {
    logic done;
    logic taken;
    logic [PC_W-1:0] pc_next;
    logic sr_we;
    logic [SR_W-1:0] sr;
  } state_t;

  state_t st;
  state_t next_st;
  logic [COND_W-1:0] cond;
  logic [OFF_W-1:0] offset;
  logic [PC_W-1:0] target;
  logic is_ge;
  logic is_lt;
  logic n_xor_v;

  assign cond = i_instr[COND_LSB +: COND_W];
  assign offset = i_instr[OFF_LSB +: OFF_W];
  assign is_ge = i_valid && (cond == COND_GE);
  assign is_lt = i_valid && (cond == COND_LT);
  assign n_xor_v = i_flag_n ^ i_flag_v;

  branch_target_calc #(
    .PC_W(PC_W),
    .OFF_W(OFF_W),
    .OFF_SHIFT(OFF_SHIFT)
  ) u_target (
    .i_pc(i_pc),
    .i_offset(offset),
    .o_target(target)
  );

  always_comb begin
    next_st = st;
    next_st.done = is_ge || is_lt;
    next_st.taken = 1'b0;
    // flags are only ever passed back untouched
    next_st.sr_we = 1'b0;
    if (is_ge || is_lt) begin
      next_st.sr = i_sr;
      next_st.pc_next = i_pc;
      if (is_ge && !n_xor_v) begin
        next_st.taken = 1'b1;
        next_st.pc_next = target;
      end else if (is_ge) begin
        next_st.pc_next = i_pc;
      end else if (n_xor_v) begin
        next_st.taken = 1'b1;
        next_st.pc_next = target;
      end else begin
        next_st.pc_next = i_pc;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '{done: 1'b0, taken: 1'b0, pc_next: PC_RST, sr_we: 1'b0, sr: SR_RST};
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
  assign o_taken = st.taken;
  assign o_pc_next = st.pc_next;
  assign o_sr_we = st.sr_we;
  assign o_sr = st.sr;

  // reference displacement, built apart from the target adder so a wrong
  // shift or a lost sign bit there shows up against it
  logic signed [PC_W-1:0] exp_disp;
  assign exp_disp = PC_W'($signed(offset)) <<< OFF_SHIFT;

  // greater-or-equal: equal flags jump, one flag alone falls through
  chk_ge_taken_jump: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && (i_flag_n == i_flag_v))
      |=> (o_done && o_taken && o_pc_next == $past(i_pc) + $past(exp_disp)))
    else $error("ge branch with equal flags did not jump");

  chk_ge_both_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && i_flag_n && i_flag_v) |=> (o_done && o_taken))
    else $error("ge branch with both flags set did not jump");

  chk_ge_both_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && !i_flag_n && !i_flag_v) |=> (o_done && o_taken))
    else $error("ge branch with both flags clear did not jump");

  chk_ge_fall_through: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && (i_flag_n != i_flag_v)) |=> (o_done && !o_taken && o_pc_next == $past(i_pc)))
    else $error("ge branch with differing flags did not fall through");

  chk_ge_only_negative: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && i_flag_n && !i_flag_v) |=> (o_done && !o_taken))
    else $error("ge branch with only the negative flag jumped");

  chk_ge_only_overflow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && !i_flag_n && i_flag_v) |=> (o_done && !o_taken))
    else $error("ge branch with only the overflow flag jumped");

  // less-than: the mirror image
  chk_lt_taken_jump: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && (i_flag_n != i_flag_v))
      |=> (o_done && o_taken && o_pc_next == $past(i_pc) + $past(exp_disp)))
    else $error("lt branch with differing flags did not jump");

  chk_lt_only_negative: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && i_flag_n && !i_flag_v) |=> (o_done && o_taken))
    else $error("lt branch with only the negative flag did not jump");

  chk_lt_only_overflow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && !i_flag_n && i_flag_v) |=> (o_done && o_taken))
    else $error("lt branch with only the overflow flag did not jump");

  chk_lt_fall_through: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && (i_flag_n == i_flag_v)) |=> (o_done && !o_taken && o_pc_next == $past(i_pc)))
    else $error("lt branch with equal flags did not fall through");

  chk_lt_both_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && i_flag_n && i_flag_v) |=> (o_done && !o_taken))
    else $error("lt branch with both flags set jumped");

  chk_lt_both_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && !i_flag_n && !i_flag_v) |=> (o_done && !o_taken))
    else $error("lt branch with both flags clear jumped");

  // every resolution: one pulse, only for the two codes, taken only with done
  chk_done_follows: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && (cond == COND_GE || cond == COND_LT)) |=> o_done)
    else $error("signed branch was not resolved on the next cycle");

  chk_refused_quiet: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond != COND_GE && cond != COND_LT) |=> (!o_done && !o_taken))
    else $error("foreign condition code produced a resolution");

  chk_refused_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond != COND_GE && cond != COND_LT) |=> ($stable(o_pc_next) && $stable(o_sr)))
    else $error("foreign condition code changed the results");

  chk_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_valid |=> (!o_done && !o_taken))
    else $error("resolution without an issued branch");

  chk_taken_with_done: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_taken |-> o_done)
    else $error("taken flag raised outside a resolution");

  chk_fall_keeps_pc: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_done && !o_taken) |-> (o_pc_next == $past(i_pc)))
    else $error("fall-through did not continue with the next instruction");

  // target arithmetic
  chk_offset_scaling: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ((i_valid && (cond == COND_GE || cond == COND_LT)) ##1 o_taken)
      |-> (o_pc_next - $past(i_pc)) == $past(exp_disp))
    else $error("taken target is not pc plus twice the offset");

  chk_target_parity: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_done && o_taken) |-> (o_pc_next[0] == $past(i_pc[0])))
    else $error("taken target moved by an odd number of bytes");

  // flags pass back untouched, and nothing moves between resolutions
  chk_flags_unchanged: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_done |-> (!o_sr_we && o_sr == $past(i_sr) && $stable(o_sr_we)))
    else $error("status flags altered by a signed branch");

  chk_result_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !o_done |-> ($stable(o_pc_next) && $stable(o_sr) && !o_sr_we))
    else $error("results changed without a resolution");

  // distance counted from the jump word, one word behind the issued pc
  chk_reach_range: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_done && o_taken) |-> ($signed(o_pc_next - $past(i_pc) + INSTR_BYTES) >= PC_W'(2 * RANGE_MIN_WORDS)
      && $signed(o_pc_next - $past(i_pc) + INSTR_BYTES) <= PC_W'(2 * RANGE_MAX_WORDS)))
    else $error("taken branch outside the single-word reach");

  // sign extension seen from both directions
  chk_sext_base: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_GE && offset[OFF_W-1] && (i_flag_n == i_flag_v))
      |=> ($signed(o_pc_next - $past(i_pc)) < 0))
    else $error("negative offset was not sign-extended");

  chk_forward_reach: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_valid && cond == COND_LT && !offset[OFF_W-1] && (i_flag_n != i_flag_v))
      |=> ($signed(o_pc_next - $past(i_pc)) >= 0))
    else $error("positive offset moved the pc backwards");

  // outputs leave reset quiet
  chk_reset_quiet: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(i_rstn) |-> (!o_done && !o_taken && !o_sr_we && o_pc_next == PC_RST && o_sr == SR_RST))
    else $error("outputs not at their reset values after reset");

endmodule // signed_conditional_branch_unit

// ===== tb/signed_conditional_branch_unit_bench.sv
`timescale 1ns/1ps
module signed_conditional_branch_unit_bench;
  import branch_unit_pkg::*;
  logic i_mclk = 0;
  logic i_rstn = 0;
  logic i_valid = 0;
  logic [INSTR_W-1:0] i_instr = '0;
  logic [PC_W-1:0] i_pc = '0;
  logic [SR_W-1:0] i_sr = '0;
  logic i_flag_n = 0;
  logic i_flag_v = 0;
  logic o_done, o_taken, o_sr_we;
  logic [PC_W-1:0] o_pc_next;
  logic [SR_W-1:0] o_sr;
  int bad_count = 0;
  int n_checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  signed_conditional_branch_unit uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(i_valid), .i_instr(i_instr),
    .i_pc(i_pc), .i_sr(i_sr), .i_flag_n(i_flag_n), .i_flag_v(i_flag_v), .o_done(o_done), .o_taken(o_taken),
    .o_pc_next(o_pc_next), .o_sr_we(o_sr_we), .o_sr(o_sr));
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic issue(logic [2:0] cond, logic [9:0] off, logic n, logic v, logic [15:0] pc, logic [15:0] sr);
    logic tk;
    logic [15:0] nxt;
    tk = (cond == COND_GE) ? ~(n ^ v) : (n ^ v);
    nxt = tk ? pc + {{5{off[9]}}, off, 1'b0} : pc;
    @(negedge i_mclk);
    i_valid = 1;
    i_instr = {3'h1, cond, off};
    i_pc = pc;
    i_sr = sr;
    i_flag_n = n;
    i_flag_v = v;
    @(negedge i_mclk);
    i_valid = 0;
    i_pc = ~pc;
    i_sr = ~sr;
    check("done", 16'h1, {15'h0, o_done});
    check("taken", {15'h0, tk}, {15'h0, o_taken});
    check("pc_next", nxt, o_pc_next);
    check("sr", sr, o_sr);
    check("sr_we", 16'h0, {15'h0, o_sr_we});
    @(negedge i_mclk);
    check("done_pulse", 16'h0, {15'h0, o_done});
    check("pc_hold", nxt, o_pc_next);
  endtask
  task automatic t_ge;
    for (int i = 0; i < 4; i++) issue(COND_GE, 10'h001, i[1], i[0], 16'h0010, 16'h0104 + 16'(i));
  endtask
  task automatic t_lt;
    for (int i = 0; i < 4; i++) issue(COND_LT, 10'h3ff, i[1], i[0], 16'h0102, 16'h0006 + 16'(i));
  endtask
  task automatic t_reach;
    issue(COND_LT, 10'h1ff, 1'b0, 1'b1, 16'h0402, 16'h0100);
    issue(COND_GE, 10'h200, 1'b1, 1'b1, 16'h0402, 16'h0003);
    issue(COND_GE, 10'h200, 1'b0, 1'b0, 16'h0100, 16'h0001);
  endtask
  task automatic t_refused;
    @(negedge i_mclk);
    i_valid = 1;
    i_instr = {3'h1, 3'h4, 10'h010};
    i_flag_n = 0;
    i_flag_v = 0;
    @(negedge i_mclk);
    i_valid = 0;
    check("refused_done", 16'h0, {15'h0, o_done});
    check("refused_pc", 16'hfd00, o_pc_next);
    check("refused_sr", 16'h0001, o_sr);
  endtask
  task automatic t_reset;
    issue(COND_GE, 10'h004, 1'b0, 1'b0, 16'h0200, 16'h0105);
    @(negedge i_mclk);
    i_rstn = 0;
    #1;
    check("rst_pc", PC_RST, o_pc_next);
    check("rst_sr", SR_RST, o_sr);
    @(negedge i_mclk);
    i_rstn = 1;
    @(negedge i_mclk);
    check("rst_done", 16'h0, {15'h0, o_done});
    check("rst_hold", PC_RST, o_pc_next);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(25 * 400);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rstn = 1;
    t_ge();
    t_lt();
    t_reach();
    t_refused();
    t_reset();
    stop_test();
  end
endmodule // signed_conditional_branch_unit_bench
